// *** src/ldsc_map.vh ***
// constants for the load diagnostic and sense control block
// Functional notes
// - faults latch, never switch channel off
// - config bits 8..6 disable each diagnostic
// - short check only while channel off
// - short live on pin, latched until read
// - off open-load checked every off period
// - off open-load pin releases, bit stays latched
// - on open-load drives pin, channel stays on
// - high ratio continuous; off read clears
// - high ratio on-read clears only if gone
// - low ratio sampled, fast slew only
// - internal pwm checks every 150 ms
// - direct input checks at each turn-off
// - config bit 5 ignores direct input
// - direct low ratio clears after clean check
// - two select bits pick sense source
// - overcurrent window disables sense, strobe high
// - track-hold bit, reset zero, picks mode
// - sync blanks after off; hold keeps sample
// - ratio bit picks ratio and thresholds
// - sync strobe low after settle until off
// - hold mode strobe high at switch-off
`ifndef LDSC_MAP_VH
`define LDSC_MAP_VH
`define LDSC_CFG_OL_ON_DIS 8
`define LDSC_CFG_OL_OFF_DIS 7
`define LDSC_CFG_SHORT_DIS 6
`define LDSC_CFG_DIR_DIS 5
`define LDSC_CFG_WIDTH 9
`define LDSC_CFG_RESET 9'h000
`define LDSC_FLT_SHORT 0
`define LDSC_FLT_OL_OFF 1
`define LDSC_FLT_OL_ON 2
`define LDSC_SEL_CH0 2'h1
`define LDSC_SEL_CH1 2'h2
`define LDSC_SEL_TEMP 2'h3
`define LDSC_CLK_HZ 50000000
`define LDSC_CHECK_PERIOD_MS 150
`define LDSC_CHECK_CYCLES ((`LDSC_CLK_HZ / 1000) * `LDSC_CHECK_PERIOD_MS)
`define LDSC_SETTLE_CYCLES 16
`endif

// *** src/ldsc_channel.v ***
// one channel of fault latching and open-load-on timing
`timescale 1ns/10ps
`default_nettype none
`include "ldsc_map.vh"
module ldsc_channel #(
   parameter CHECK_CYCLES = `LDSC_CHECK_CYCLES
)
(
   input wire i_mclk, // system clock
   input wire i_reset_n, // async reset, active low
   input wire [`LDSC_CFG_WIDTH-1:0] i_cfg, // channel config bits
   input wire i_low_ratio, // 1 selects low sense ratio
   input wire i_fast_slew, // fast slew selected
   input wire i_int_pwm, // internal pwm drives the channel
   input wire i_pwm_on, // internal pwm gate
   input wire i_direct_in, // direct input pin
   input wire i_short_cmp, // output above short threshold
   input wire i_ol_off_cmp, // output above open-load threshold (off)
   input wire i_ol_on_cmp, // load current below open-load threshold (on)
   input wire i_fault_read, // fault register read strobe
   output reg o_on, // channel gate
   output reg o_off_edge, // one-cycle pulse at turn-off
   output wire o_live_fault, // enabled live fault present
   output reg [2:0] o_fault_data, // read data, pre-clear bits
   output reg [2:0] o_faults // latched fault bits
);
   reg [31:0] period_cnt; // time since last low-ratio check
   reg [31:0] on_cnt; // unbroken on time, for 100% duty
   reg clean_check; // last low-ratio check found no fault
   reg ol_on_live; // live open-load-on indication
   wire gate; // selected gate source
   wire short_en; // short check enabled
   wire off_en; // off open-load enabled
   wire on_en; // on open-load enabled
   wire period_done; // 150 ms elapsed
   wire on_done; // on for a whole period without a turn-off
   wire check_now; // low-ratio check instant
   wire short_set; // short event
   wire off_set; // off open-load event
   wire on_set; // on open-load event
   wire on_clr; // open-load-on clear on read
   assign gate = i_int_pwm ? i_pwm_on :
                 (i_direct_in & ~i_cfg[`LDSC_CFG_DIR_DIS]);
   assign short_en = ~i_cfg[`LDSC_CFG_SHORT_DIS];
   assign off_en = ~i_cfg[`LDSC_CFG_OL_OFF_DIS];
   assign on_en = ~i_cfg[`LDSC_CFG_OL_ON_DIS];
   assign period_done = (period_cnt >= CHECK_CYCLES - 1);
   assign on_done = (on_cnt >= CHECK_CYCLES - 1);
   // low ratio checks only on fast slew; internal pwm also checks at 100% duty
   assign check_now = i_low_ratio & i_fast_slew & on_en & o_on &
                      (i_int_pwm ? (period_done & (~gate | on_done)) : ~gate);
   assign short_set = short_en & ~o_on & i_short_cmp;
   assign off_set = off_en & ~o_on & i_ol_off_cmp;
   assign on_set = i_low_ratio ? (check_now & i_ol_on_cmp) :
                   (on_en & o_on & i_ol_on_cmp);
   // clear condition depends on ratio and mode
   assign on_clr = i_low_ratio ? (~i_int_pwm ? clean_check : 1'b1) :
                   (~o_on | ~i_ol_on_cmp);
   assign o_live_fault = short_set | off_set | ol_on_live;
   ////////////////////////////////////////////////////////////////////
   // gate follows command only; faults never turn off
   always @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_on <= 1'b0;
         o_off_edge <= 1'b0;
      end
      else
      begin
         o_on <= gate;
         o_off_edge <= o_on & ~gate;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // periodic timer; holds at period end until the check, restarts per check
   always @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         period_cnt <= 32'h00000000;
      else if (check_now)
         period_cnt <= 32'h00000000;
      else if (!period_done)
         period_cnt <= period_cnt + 32'h00000001;
   end
   ////////////////////////////////////////////////////////////////////
   // on-time counter; without it a pwm that never turns off is never checked
   always @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         on_cnt <= 32'h00000000;
      else if (!o_on || check_now)
         on_cnt <= 32'h00000000;
      else if (!on_done)
         on_cnt <= on_cnt + 32'h00000001;
   end
   ////////////////////////////////////////////////////////////////////
   // live open-load-on: continuous at high ratio, sampled at low ratio
   always @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ol_on_live <= 1'b0;
         clean_check <= 1'b0;
      end
      else
      begin
         if (!i_low_ratio)
            ol_on_live <= on_en & o_on & i_ol_on_cmp;
         else if (check_now)
            ol_on_live <= i_ol_on_cmp;
         else if (!on_en)
            ol_on_live <= 1'b0;
         if (check_now)
            clean_check <= ~i_ol_on_cmp;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // latched fault bits; set wins over read clear
   always @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_faults <= 3'h0;
         o_fault_data <= 3'h0;
      end
      else
      begin
         if (i_fault_read)
            o_fault_data <= o_faults;
         o_faults[`LDSC_FLT_SHORT] <= short_set |
            (o_faults[`LDSC_FLT_SHORT] & ~i_fault_read);
         o_faults[`LDSC_FLT_OL_OFF] <= off_set |
            (o_faults[`LDSC_FLT_OL_OFF] & ~i_fault_read);
         o_faults[`LDSC_FLT_OL_ON] <= on_set |
            (o_faults[`LDSC_FLT_OL_ON] & ~(i_fault_read & on_clr));
      end
   end
endmodule // ldsc_channel
`default_nettype wire

// *** src/ldsc_top.v ***
// two-channel diagnostic and current-sense control
`timescale 1ns/10ps
`default_nettype none
`include "ldsc_map.vh"
module ldsc_top #(
   parameter CHECK_CYCLES = `LDSC_CHECK_CYCLES, // low-ratio check period
   parameter SETTLE_CYCLES = `LDSC_SETTLE_CYCLES // sense settling time
)
(
   input wire i_mclk, // system clock
   input wire i_reset_n, // async reset, active low
   input wire [`LDSC_CFG_WIDTH-1:0] i_cfg0, // channel 0 config
   input wire [`LDSC_CFG_WIDTH-1:0] i_cfg1, // channel 1 config
   input wire [1:0] i_sense_sel, // sense select bits b,a
   input wire i_track_hold, // 1 track-and-hold, 0 synchronous
   input wire i_low_ratio, // sense ratio bit
   input wire [1:0] i_fast_slew, // fast slew per channel
   input wire [1:0] i_int_pwm, // internal pwm mode per channel
   input wire [1:0] i_pwm_on, // internal pwm gate per channel
   input wire [1:0] i_direct_in, // direct input pins
   input wire [1:0] i_short_cmp, // short comparators
   input wire [1:0] i_ol_off_cmp, // off open-load comparators
   input wire [1:0] i_ol_on_cmp, // on open-load comparators
   input wire [1:0] i_oc_window, // overcurrent window active
   input wire i_fault_read, // fault register read strobe
   output wire [1:0] o_on, // channel gates
   output wire [5:0] o_faults, // latched bits, ch1 in [5:3]
   output wire [5:0] o_fault_data, // read data, ch1 in [5:3]
   output reg o_fault_status_n, // fault status pin, active low
   output reg o_sense_valid_strobe_n, // sense valid sync, active low
   output reg [1:0] o_sense_src, // 0 none, 1 ch0, 2 ch1, 3 temp
   output reg o_sense_hold, // sense presents held sample
   output reg o_sense_low_ratio, // ratio for sense mirror
   output reg o_oc_low_thresh // low overcurrent threshold set
);
   wire [1:0] live; // live faults per channel
   wire [1:0] off_edge; // turn-off pulses
   reg [15:0] settle_cnt; // settle timer
   reg [1:0] src; // next sense source
   wire ch_sel; // sensed channel index
   wire sel_is_ch; // a channel is sensed
   wire sel_on; // sensed channel is on
   wire sel_off_edge; // sensed channel turning off
   wire sel_oc; // overcurrent window on sensed channel
   genvar g;
   ////////////////////////////////////////////////////////////////////
   // per-channel diagnostics
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : ch
         ldsc_channel #(
            .CHECK_CYCLES(CHECK_CYCLES)
         ) u_ch (
            .i_mclk(i_mclk),
            .i_reset_n(i_reset_n),
            .i_cfg(g == 0 ? i_cfg0 : i_cfg1),
            .i_low_ratio(i_low_ratio),
            .i_fast_slew(i_fast_slew[g]),
            .i_int_pwm(i_int_pwm[g]),
            .i_pwm_on(i_pwm_on[g]),
            .i_direct_in(i_direct_in[g]),
            .i_short_cmp(i_short_cmp[g]),
            .i_ol_off_cmp(i_ol_off_cmp[g]),
            .i_ol_on_cmp(i_ol_on_cmp[g]),
            .i_fault_read(i_fault_read),
            .o_on(o_on[g]),
            .o_off_edge(off_edge[g]),
            .o_live_fault(live[g]),
            .o_fault_data(o_fault_data[g*3+2:g*3]),
            .o_faults(o_faults[g*3+2:g*3])
         );
      end
   endgenerate
   assign ch_sel = (i_sense_sel == `LDSC_SEL_CH1);
   assign sel_is_ch = (i_sense_sel == `LDSC_SEL_CH0) | (i_sense_sel == `LDSC_SEL_CH1);
   assign sel_on = sel_is_ch & o_on[ch_sel];
   assign sel_off_edge = sel_is_ch & off_edge[ch_sel];
   assign sel_oc = sel_is_ch & i_oc_window[ch_sel];
   ////////////////////////////////////////////////////////////////////
   // fault pin: registered OR of enabled live faults
   always @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_fault_status_n <= 1'b1;
      else
         o_fault_status_n <= ~(|live);
   end
   ////////////////////////////////////////////////////////////////////
   // ratio and threshold set follow the ratio bit
   always @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_sense_low_ratio <= 1'b0;
         o_oc_low_thresh <= 1'b0;
      end
      else
      begin
         o_sense_low_ratio <= i_low_ratio;
         o_oc_low_thresh <= i_low_ratio;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // sense source: blank during overcurrent, or after off in sync mode
   always @*
   begin
      src = i_sense_sel;
      if (sel_oc)
         src = 2'h0;
      else if (sel_is_ch & ~sel_on & ~i_track_hold)
         src = 2'h0;
   end
   ////////////////////////////////////////////////////////////////////
   // settle timer and sense-valid strobe
   always @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         settle_cnt <= 16'h0000;
         o_sense_valid_strobe_n <= 1'b1;
         o_sense_src <= 2'h0;
         o_sense_hold <= 1'b0;
      end
      else
      begin
         o_sense_src <= src;
         if (sel_oc | ~sel_on)
         begin
            settle_cnt <= 16'h0000;
            o_sense_valid_strobe_n <= 1'b1;
         end
         else if (settle_cnt < SETTLE_CYCLES[15:0])
            settle_cnt <= settle_cnt + 16'h0001;
         else
            o_sense_valid_strobe_n <= 1'b0;
         // hold mode: sample at switch-off, drop at next turn-on
         if (!i_track_hold | sel_oc)
            o_sense_hold <= 1'b0;
         else if (sel_off_edge)
            o_sense_hold <= 1'b1;
         else if (sel_on)
            o_sense_hold <= 1'b0;
      end
   end
endmodule // ldsc_top
`default_nettype wire

// *** verification/ldsc_checker.sv ***
// checker bound to the diagnostic and sense block
`timescale 1ns/10ps
`default_nettype none
module ldsc_checker #(
   parameter CHECK_CYCLES = 50, // low-ratio check period
   parameter SETTLE_CYCLES = 4 // sense settle time
)
(
   input wire logic i_mclk, i_reset_n, i_low_ratio, i_fault_read, // clock, reset, ratio, read
   input wire logic [8:0] i_cfg0, // channel 0 config
   input wire logic [1:0] i_sense_sel, i_int_pwm, i_pwm_on, i_direct_in, // select and gate
   input wire logic [1:0] i_short_cmp, i_ol_on_cmp, i_oc_window, // comparators
   input wire logic [1:0] o_on, // channel gates
   input wire logic [5:0] o_faults, o_fault_data, // latched and read bits
   input wire logic o_fault_status_n, o_sense_valid_strobe_n // status pins
);
////////////////////////////////////////
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);
   // faults never enter the gate, so o_on must follow this alone
   wire gate0 = i_int_pwm[0] ? i_pwm_on[0] : i_direct_in[0] & ~i_cfg0[5];
////////////////////////////////////////
   chk_gate_follow: assert property ($past(i_reset_n) |-> o_on[0] == $past(gate0))
      else $error("gate not followed");
   chk_short_set: assert property (!o_on[0] && i_short_cmp[0] && !i_cfg0[6] |=> o_faults[0])
      else $error("short not latched");
   chk_short_mask: assert property (i_cfg0[6] && !o_faults[0] |=> !o_faults[0])
      else $error("masked short latched");
   chk_short_pin: assert property (!o_on[0] && i_short_cmp[0] && !i_cfg0[6] |=> !o_fault_status_n)
      else $error("short not on pin");
   chk_read_data: assert property (i_fault_read |=> o_fault_data == $past(o_faults))
      else $error("read data not pre-clear bits");
   chk_open_load_on_fault_keep: assert property (i_fault_read && o_faults[2] && o_on[0] && i_ol_on_cmp[0]
      && !i_low_ratio |=> o_faults[2])
      else $error("open-load-on cleared while present");
   chk_open_load_on_fault_offclr: assert property (i_fault_read && !o_on[0] && !$past(o_on[0])
      && !i_low_ratio |=> !o_faults[2])
      else $error("open-load-on kept after off read");
   chk_oc_strobe: assert property (i_oc_window[0] && i_sense_sel == 2'h1
      |=> o_sense_valid_strobe_n)
      else $error("strobe low in overcurrent window");
   // main scenarios reached
   cover property (i_fault_read && o_faults[2]);
   cover property ($fell(o_fault_status_n));
   cover property ($fell(o_sense_valid_strobe_n));
   cover property (i_int_pwm[0] && i_low_ratio && $rose(o_faults[2]));
endmodule // ldsc_checker
bind ldsc_top ldsc_checker #(.CHECK_CYCLES(CHECK_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
   .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_low_ratio(i_low_ratio),
   .i_fault_read(i_fault_read), .i_cfg0(i_cfg0), .i_sense_sel(i_sense_sel),
   .i_int_pwm(i_int_pwm), .i_pwm_on(i_pwm_on), .i_direct_in(i_direct_in),
   .i_short_cmp(i_short_cmp), .i_ol_on_cmp(i_ol_on_cmp), .i_oc_window(i_oc_window),
   .o_on(o_on), .o_faults(o_faults), .o_fault_data(o_fault_data),
   .o_fault_status_n(o_fault_status_n), .o_sense_valid_strobe_n(o_sense_valid_strobe_n));
`default_nettype wire

// *** verification/ldsc_mcu_model.sv ***
// microcontroller model that reads the fault register
`timescale 1ns/10ps
`default_nettype none
module ldsc_mcu_model
(
   input wire logic i_mclk, // system clock
   input wire logic i_go, // request one read
   input wire logic [5:0] i_fault_data, // read data from device
   output var logic o_fault_read = 1'b0, // read strobe, one cycle
   output var logic [5:0] o_data = 6'h00 // captured read data
);
   logic pend = 1'b0; // strobe was taken at the last edge
////////////////////////////////////////
   // data lands at the edge that takes the strobe, so capture one edge later
   always @(posedge i_mclk)
   begin
      o_fault_read <= #1 i_go;
      pend <= o_fault_read;
      if (pend)
      begin
         o_data <= i_fault_data;
      end
   end
endmodule // ldsc_mcu_model
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the diagnostic and sense block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam SETTLE = 4; // short settle count keeps the run brief
   typedef struct {logic [8:0] cfg; logic [1:0] cmp; logic [5:0] flt;} ldsc_row_t;
   logic i_mclk, i_reset_n, i_track_hold, i_low_ratio, go;
   logic [8:0] i_cfg0, i_cfg1;
   logic [1:0] i_sense_sel, i_fast_slew, i_int_pwm, i_pwm_on, i_direct_in;
   logic [1:0] i_short_cmp, i_ol_off_cmp, i_ol_on_cmp, i_oc_window;
   wire [1:0] o_on, o_sense_src;
   wire [5:0] o_faults, o_fault_data, rd_data;
   wire rd, pin_n, strobe_n, hold, low_ratio, low_thresh;
   int failures, tests_run, n;
   // off-state rows: config, {off open-load, short} comparators, latched bits
   ldsc_row_t rows [4] = '{'{9'h000, 2'h1, 6'h01}, '{9'h000, 2'h2, 6'h02},
      '{9'h040, 2'h1, 6'h00}, '{9'h080, 2'h3, 6'h01}};
   ldsc_top #(.CHECK_CYCLES(50), .SETTLE_CYCLES(SETTLE)) i_dut (.i_mclk(i_mclk),
      .i_reset_n(i_reset_n), .i_cfg0(i_cfg0), .i_cfg1(i_cfg1), .i_sense_sel(i_sense_sel),
      .i_track_hold(i_track_hold), .i_low_ratio(i_low_ratio), .i_fast_slew(i_fast_slew),
      .i_int_pwm(i_int_pwm), .i_pwm_on(i_pwm_on), .i_direct_in(i_direct_in),
      .i_short_cmp(i_short_cmp), .i_ol_off_cmp(i_ol_off_cmp), .i_ol_on_cmp(i_ol_on_cmp),
      .i_oc_window(i_oc_window), .i_fault_read(rd), .o_on(o_on), .o_faults(o_faults),
      .o_fault_data(o_fault_data), .o_fault_status_n(pin_n),
      .o_sense_valid_strobe_n(strobe_n), .o_sense_src(o_sense_src), .o_sense_hold(hold),
      .o_sense_low_ratio(low_ratio), .o_oc_low_thresh(low_thresh));
   ldsc_mcu_model i_mcu (.i_mclk(i_mclk), .i_go(go), .i_fault_data(o_fault_data),
      .o_fault_read(rd), .o_data(rd_data));
////////////////////////////////////////
   // inputs move 1 ns after the edge, away from sampling
   task automatic step(input int c);
      repeat (c) @(posedge i_mclk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one read through the model; data is captured when this returns
   task automatic read_faults();
      go = 1'b1;
      step(1);
      go = 1'b0;
      step(3);
   endtask
   task automatic pulse();
      i_direct_in[0] = 1'b1;
      step(5);
      i_direct_in[0] = 1'b0;
      step(4);
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
////////////////////////////////////////
   initial
   begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #100000;
      failures++;
      complete_run();
   end
   initial
   begin
      failures = 0;
      tests_run = 0;
      {i_reset_n, i_track_hold, i_low_ratio, go, i_cfg0, i_cfg1, i_sense_sel} = '0;
      {i_fast_slew, i_int_pwm, i_pwm_on, i_direct_in, i_short_cmp} = '0;
      {i_ol_off_cmp, i_ol_on_cmp, i_oc_window} = '0;
      step(12);
      chk(8'({pin_n, strobe_n, o_faults}), 8'hC0);
      i_reset_n = 1'b1;
      step(2);
      foreach (rows[r])
      begin
         i_cfg0 = rows[r].cfg;
         {i_ol_off_cmp[0], i_short_cmp[0]} = rows[r].cmp;
         step(3);
         chk(8'({pin_n, o_faults}), 8'({rows[r].flt == 6'h00, rows[r].flt}));
         {i_ol_off_cmp[0], i_short_cmp[0]} = 2'h0;
         step(2);
         chk(8'({pin_n, o_faults}), 8'({1'b1, rows[r].flt}));
         read_faults();
         chk(8'(rd_data), 8'(rows[r].flt));
         chk(8'(o_faults), 8'h00);
      end
      // high ratio open-load while on
      i_cfg0 = 9'h000;
      i_direct_in[0] = 1'b1;
      i_ol_on_cmp[0] = 1'b1;
      step(4);
      chk({o_on[0], pin_n, o_faults}, 8'h84);
      read_faults();
      chk(8'(o_faults), 8'h04);
      i_ol_on_cmp[0] = 1'b0;
      step(3);
      chk(8'({pin_n, o_faults}), 8'h44);
      read_faults();
      chk(8'(o_faults), 8'h00);
      i_ol_on_cmp[0] = 1'b1;
      step(3);
      i_direct_in[0] = 1'b0;
      step(3);
      read_faults();
      chk(8'(o_faults), 8'h00);
      // low ratio, direct input: checked only at turn-off with fast slew
      i_low_ratio = 1'b1;
      pulse();
      chk(8'(o_faults), 8'h00);
      chk(8'({low_ratio, low_thresh}), 8'h03);
      i_fast_slew[0] = 1'b1;
      pulse();
      chk(8'(o_faults), 8'h04);
      read_faults();
      chk(8'(o_faults), 8'h04);
      i_ol_on_cmp[0] = 1'b0;
      pulse();
      read_faults();
      chk(8'(o_faults), 8'h00);
      i_cfg0 = 9'h020;
      i_direct_in[0] = 1'b1;
      i_low_ratio = 1'b0;
      step(3);
      chk(8'({o_on, low_ratio, low_thresh}), 8'h00);
      i_cfg0 = 9'h000;
      i_direct_in = 2'h3;
      for (n = 0; n < 4; n++)
      begin
         i_sense_sel = n[1:0];
         step(2);
         chk(8'(o_sense_src), 8'(n));
      end
      i_sense_sel = 2'h1;
      i_direct_in = 2'h0;
      step(3);
      i_direct_in[0] = 1'b1;
      step(1);
      for (n = 0; strobe_n !== 1'b0 && n < 20; n++)
         step(1);
      chk(8'(n >= SETTLE - 1 && n <= SETTLE + 2), 8'h01);
      i_oc_window[0] = 1'b1;
      step(2);
      chk(8'(strobe_n), 8'h01);
      i_oc_window[0] = 1'b0;
      step(SETTLE + 4);
      chk(8'(strobe_n), 8'h00);
      i_direct_in[0] = 1'b0;
      step(3);
      chk(8'({strobe_n, hold, o_sense_src}), 8'h08);
      i_track_hold = 1'b1;
      i_direct_in[0] = 1'b1;
      step(SETTLE + 4);
      i_direct_in[0] = 1'b0;
      step(3);
      chk(8'({strobe_n, hold, o_sense_src}), 8'h0D);
      // internal pwm, low ratio: one check per period, also at 100% duty
      i_low_ratio = 1'b1;
      {i_int_pwm[0], i_pwm_on[0], i_ol_on_cmp[0]} = 3'h7;
      step(20);
      chk(8'(o_faults), 8'h00);
      step(40);
      chk(8'(o_faults), 8'h04);
      read_faults();
      chk(8'(o_faults), 8'h00);
      i_pwm_on[0] = 1'b0;
      step(5);
      chk(8'(o_faults), 8'h00);
      step(40);
      i_pwm_on[0] = 1'b1;
      step(3);
      i_pwm_on[0] = 1'b0;
      step(3);
      chk(8'(o_faults), 8'h04);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
